// *** pww_pkg.sv ***
// Package for the power-mode and watchdog block: register map, fields,
// reset values, power states and timing constants.
// Assumes a 250 MHz system clock and a 16-bit software register port.
package pww_pkg;

    // ==========================================================
    // Bus shape
    localparam int PWW_DATA_W = 16;
    localparam int PWW_ADDR_W = 3;

    // ==========================================================
    // Register indices
    localparam logic [PWW_ADDR_W-1:0] PWW_ADDR_CTRL   = 3'h0;
    localparam logic [PWW_ADDR_W-1:0] PWW_ADDR_PMODE  = 3'h1;
    localparam logic [PWW_ADDR_W-1:0] PWW_ADDR_CLEAR  = 3'h2;
    localparam logic [PWW_ADDR_W-1:0] PWW_ADDR_STATUS = 3'h3;
    localparam logic [PWW_ADDR_W-1:0] PWW_ADDR_COUNT  = 3'h4;

    // ==========================================================
    // Control fields and reset values
    localparam int PWW_CTRL_EN_BIT   = 0;
    localparam int PWW_CTRL_RSEL_BIT = 1;
    localparam int PWW_CTRL_PSEL_LSB = 2;
    localparam int PWW_PSEL_W        = 3;
    localparam logic                  PWW_CTRL_EN_RST   = 1'b1;
    localparam logic                  PWW_CTRL_RSEL_RST = 1'b0;
    localparam logic [PWW_PSEL_W-1:0] PWW_PSEL_DEFAULT  = 3'h5;
    localparam logic [PWW_PSEL_W-1:0] PWW_PSEL_MAX      = 3'h5;

    // ==========================================================
    // Status fields
    localparam int PWW_STAT_FIRED_BIT = 0;
    localparam int PWW_STAT_CAUSE_BIT = 1;
    localparam int PWW_STAT_MODE_LSB  = 2;

    // ==========================================================
    // Clear key: high nibble and low nibble, middle bits ignored
    localparam int         PWW_KEY_HI_LSB = 12;
    localparam int         PWW_KEY_LO_LSB = 0;
    localparam int         PWW_KEY_W      = 4;
    localparam logic [3:0] PWW_KEY_HI     = 4'ha;
    localparam logic [3:0] PWW_KEY_LO     = 4'h5;

    // ==========================================================
    // Power modes as software writes them, and the state encoding
    localparam int         PWW_MODE_W    = 2;
    localparam logic [1:0] PWW_MODE_RUN  = 2'h0;
    localparam logic [1:0] PWW_MODE_WAIT = 2'h1;
    localparam logic [1:0] PWW_MODE_HALT = 2'h2;
    localparam logic [1:0] PWW_MODE_STBY = 2'h3;

    typedef enum logic [1:0] {
        PWW_RUN  = 2'h0,
        PWW_WAIT = 2'h1,
        PWW_HALT = 2'h3,
        PWW_STBY = 2'h2
    } pww_state_type;

    // ==========================================================
    // Timing
    localparam longint PWW_CLK_HZ      = 250_000_000;
    localparam longint PWW_SLOW_HZ     = 32768;
    localparam longint PWW_US_PER_S    = 1_000_000;
    localparam longint PWW_WDOG_MIN_US = 62_500;
    localparam longint PWW_WDOG_MAX_US = 2_000_000;
    localparam int PWW_SLOW_DIV_CYCLES = int'(PWW_CLK_HZ / PWW_SLOW_HZ);
    localparam int PWW_WDOG_BASE_TICKS = int'(PWW_WDOG_MIN_US * PWW_SLOW_HZ / PWW_US_PER_S);
    localparam int PWW_DIV_W = 16;
    localparam int PWW_CNT_W = 17;

endpackage : pww_pkg

// *** pww_tick_div.sv ***
// Divider that makes the one-cycle 32768 Hz enable from the system clock.
// Assumes the enable input comes from logic on the same clock.
`timescale 1ns/1ps

module pww_tick_div
    import pww_pkg::*;
#(
    parameter int DIV = PWW_SLOW_DIV_CYCLES
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic run_en,
    output logic      tick
);

    logic [PWW_DIV_W-1:0] cnt_r;
    logic [PWW_DIV_W-1:0] cnt_nxt;
    logic                 tick_r;
    logic                 tick_nxt;

    // ==========================================================
    // Divider
    // Stops and holds while the slow clock is off, like a gated oscillator
    always_comb begin
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (run_en) begin
            if (cnt_r == PWW_DIV_W'(DIV - 1)) begin
                cnt_nxt  = '0;
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;

    property p_tick_stops;
        @(posedge clock) disable iff (!rst_n)
        !run_en |=> !tick_r;
    endproperty
    a_tick_stops: assert property (p_tick_stops)
        else $error("slow tick while the slow clock is off");

endmodule : pww_tick_div

// *** pww_core.sv ***
// Power-mode control, interrupt wakeup and watchdog, top level.
// Assumes irq comes from the interrupt controller on the same clock and that
// the system feeds sys_rst_req back into rst_n after its own stretching.
//
// Behaviour
// - Software can put the CPU into wait, halt or standby instead of running.
// - After reset the block is in run and stays there until software asks for a mode.
// - In wait any interrupt wakes it to run with no reset, so the CPU carries on.
// - In halt or standby any interrupt wakes it to run and pulses a CPU reset.
// - An expired watchdog pulses a system reset or a CPU reset, chosen in control.
// - A valid clear before expiry restarts the count and causes no reset.
// - Software can disable the watchdog and then no watchdog reset occurs.
// - The period runs from 62.5 ms to 2 s in doublings, and 2 s is the reset choice.
// - Only a clear value of the form Axx5 hex counts as a valid clear.
// - The watchdog keeps counting in wait and halt, where the slow clock runs.
`timescale 1ns/1ps

module pww_core
    import pww_pkg::*;
#(
    parameter int DIV_CYCLES = PWW_SLOW_DIV_CYCLES,
    parameter int WDOG_BASE  = PWW_WDOG_BASE_TICKS
) (
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    input  wire logic [PWW_ADDR_W-1:0] addr,
    input  wire logic [PWW_DATA_W-1:0] wr_data,
    input  wire logic                  wr_en,
    input  wire logic                  rd_en,
    output logic      [PWW_DATA_W-1:0] rd_data,
    input  wire logic                  irq,
    output logic                       cpu_clk_en,
    output logic                       sys_clk_en,
    output logic                       slow_clk_en,
    output logic                       cpu_rst_req,
    output logic                       sys_rst_req
);

    // ==========================================================
    // Declarations
    pww_state_type             state_r;
    pww_state_type             state_nxt;
    logic                      wd_en_r;
    logic                      wd_en_nxt;
    logic                      rsel_r;
    logic                      rsel_nxt;
    logic [PWW_PSEL_W-1:0]     psel_r;
    logic [PWW_PSEL_W-1:0]     psel_nxt;
    logic [PWW_CNT_W-1:0]      count_r;
    logic [PWW_CNT_W-1:0]      count_nxt;
    logic                      fired_r;
    logic                      fired_nxt;
    logic                      cause_r;
    logic                      cause_nxt;
    logic                      cpu_rst_r;
    logic                      cpu_rst_nxt;
    logic                      sys_rst_r;
    logic                      sys_rst_nxt;
    logic [PWW_DATA_W-1:0]     rdata_r;
    logic [PWW_DATA_W-1:0]     rdata_nxt;
    logic                      slow_tick;
    logic                      wd_tick;
    logic                      clear_hit;
    logic                      mode_wr;
    logic                      expire;
    logic                      wake_rst;
    logic [PWW_PSEL_W-1:0]     psel_eff;
    logic [PWW_CNT_W-1:0]      limit;
    logic [PWW_MODE_W-1:0]     mode_code;

    // ==========================================================
    // Slow clock enable
    // The divider runs only while the 32 kHz source would be on
    pww_tick_div #(
        .DIV    (DIV_CYCLES)
    ) u_tick (
        .clock  (clock),
        .rst_n  (rst_n),
        .run_en (slow_clk_en),
        .tick   (slow_tick)
    );

    // ==========================================================
    // Decodes shared by the processes
    // A tick still in flight when standby begins is dropped here
    assign wd_tick   = slow_tick && (state_r != PWW_STBY);
    assign clear_hit = wr_en && (addr == PWW_ADDR_CLEAR)
                    && (wr_data[PWW_KEY_HI_LSB +: PWW_KEY_W] == PWW_KEY_HI)
                    && (wr_data[PWW_KEY_LO_LSB +: PWW_KEY_W] == PWW_KEY_LO);
    assign mode_wr   = wr_en && (addr == PWW_ADDR_PMODE)
                    && (wr_data[PWW_MODE_W-1:0] != PWW_MODE_RUN);
    // Codes above the top step clamp to 2 s rather than wrapping short
    assign psel_eff  = (psel_r > PWW_PSEL_MAX) ? PWW_PSEL_MAX : psel_r;
    assign limit     = PWW_CNT_W'(WDOG_BASE) << psel_eff;
    // Greater-or-equal covers a period shortened below the running count
    assign expire    = wd_en_r && wd_tick && !clear_hit
                    && (count_r >= limit - 1'b1);

    // ==========================================================
    // Power state machine
    always_comb begin
        state_nxt = state_r;
        wake_rst  = 1'b0;
        unique case (state_r)
            PWW_RUN: begin
                if (mode_wr) begin
                    unique case (wr_data[PWW_MODE_W-1:0])
                        PWW_MODE_WAIT: state_nxt = PWW_WAIT;
                        PWW_MODE_HALT: state_nxt = PWW_HALT;
                        PWW_MODE_STBY: state_nxt = PWW_STBY;
                        default:       state_nxt = PWW_RUN;
                    endcase
                end
            end
            PWW_WAIT: begin
                if (irq) begin
                    state_nxt = PWW_RUN;
                end
            end
            PWW_HALT, PWW_STBY: begin
                if (irq) begin
                    state_nxt = PWW_RUN;
                    wake_rst  = 1'b1;
                end
            end
        endcase
        // A watchdog reset restarts the program, so the CPU must run again
        if (expire) begin
            state_nxt = PWW_RUN;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r <= PWW_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // Control register
    always_comb begin
        wd_en_nxt = wd_en_r;
        rsel_nxt  = rsel_r;
        psel_nxt  = psel_r;
        if (wr_en && (addr == PWW_ADDR_CTRL)) begin
            wd_en_nxt = wr_data[PWW_CTRL_EN_BIT];
            rsel_nxt  = wr_data[PWW_CTRL_RSEL_BIT];
            psel_nxt  = wr_data[PWW_CTRL_PSEL_LSB +: PWW_PSEL_W];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wd_en_r <= PWW_CTRL_EN_RST;
            rsel_r  <= PWW_CTRL_RSEL_RST;
            psel_r  <= PWW_PSEL_DEFAULT;
        end else begin
            wd_en_r <= wd_en_nxt;
            rsel_r  <= rsel_nxt;
            psel_r  <= psel_nxt;
        end
    end

    // ==========================================================
    // Watchdog counter, reset pulses and sticky status
    // Disabling also zeroes the count so re-enabling gives a full period
    always_comb begin
        count_nxt   = count_r;
        fired_nxt   = fired_r;
        cause_nxt   = cause_r;
        sys_rst_nxt = 1'b0;
        cpu_rst_nxt = wake_rst;
        if (!wd_en_r || clear_hit) begin
            count_nxt = '0;
        end else if (expire) begin
            count_nxt = '0;
        end else if (wd_tick) begin
            count_nxt = count_r + 1'b1;
        end
        // Wrong-key writes fall through the branches above untouched
        if (wr_en && (addr == PWW_ADDR_STATUS) && wr_data[PWW_STAT_FIRED_BIT]) begin
            fired_nxt = 1'b0;
        end
        // Set wins over a clear written in the same cycle
        if (expire) begin
            fired_nxt = 1'b1;
            cause_nxt = rsel_r;
            if (rsel_r) begin
                cpu_rst_nxt = 1'b1;
            end else begin
                sys_rst_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count_r   <= '0;
            fired_r   <= 1'b0;
            cause_r   <= 1'b0;
            sys_rst_r <= 1'b0;
            cpu_rst_r <= 1'b0;
        end else begin
            count_r   <= count_nxt;
            fired_r   <= fired_nxt;
            cause_r   <= cause_nxt;
            sys_rst_r <= sys_rst_nxt;
            cpu_rst_r <= cpu_rst_nxt;
        end
    end

    // ==========================================================
    // Read port: data stands for exactly one cycle after the strobe
    always_comb begin
        unique case (state_r)
            PWW_RUN:  mode_code = PWW_MODE_RUN;
            PWW_WAIT: mode_code = PWW_MODE_WAIT;
            PWW_HALT: mode_code = PWW_MODE_HALT;
            PWW_STBY: mode_code = PWW_MODE_STBY;
        endcase
        rdata_nxt = '0;
        if (rd_en) begin
            unique case (addr)
                PWW_ADDR_CTRL: begin
                    rdata_nxt[PWW_CTRL_EN_BIT]                  = wd_en_r;
                    rdata_nxt[PWW_CTRL_RSEL_BIT]                = rsel_r;
                    rdata_nxt[PWW_CTRL_PSEL_LSB +: PWW_PSEL_W]  = psel_r;
                end
                PWW_ADDR_PMODE: begin
                    rdata_nxt[PWW_MODE_W-1:0] = mode_code;
                end
                PWW_ADDR_STATUS: begin
                    rdata_nxt[PWW_STAT_FIRED_BIT]               = fired_r;
                    rdata_nxt[PWW_STAT_CAUSE_BIT]               = cause_r;
                    rdata_nxt[PWW_STAT_MODE_LSB +: PWW_MODE_W]  = mode_code;
                end
                PWW_ADDR_COUNT: begin
                    rdata_nxt = count_r[PWW_CNT_W-1 -: PWW_DATA_W];
                end
                default: rdata_nxt = '0; // Clear register and holes read zero
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign rd_data     = rdata_r;
    assign cpu_clk_en  = (state_r == PWW_RUN);
    assign sys_clk_en  = (state_r == PWW_RUN) || (state_r == PWW_WAIT);
    assign slow_clk_en = (state_r != PWW_STBY);
    assign cpu_rst_req = cpu_rst_r;
    assign sys_rst_req = sys_rst_r;

    // ==========================================================
    // Checks
    property p_halt_entry;
        @(posedge clock) disable iff (!rst_n)
        (state_r == PWW_RUN) && mode_wr && (wr_data[PWW_MODE_W-1:0] == PWW_MODE_HALT)
            && !expire |=> (state_r == PWW_HALT) && !cpu_clk_en && !sys_clk_en;
    endproperty
    a_halt_entry: assert property (p_halt_entry)
        else $error("halt request not taken");

    property p_run_hold;
        @(posedge clock) disable iff (!rst_n)
        (state_r == PWW_RUN) && !mode_wr |=> (state_r == PWW_RUN);
    endproperty
    a_run_hold: assert property (p_run_hold)
        else $error("left run without a mode request");

    property p_wait_wake;
        @(posedge clock) disable iff (!rst_n)
        (state_r == PWW_WAIT) && irq && !expire
            |=> (state_r == PWW_RUN) && !cpu_rst_req ##1 !cpu_rst_req;
    endproperty
    a_wait_wake: assert property (p_wait_wake)
        else $error("wait wakeup wrong or reset the cpu");

    property p_deep_wake;
        @(posedge clock) disable iff (!rst_n)
        ((state_r == PWW_HALT) || (state_r == PWW_STBY)) && irq
            |=> (state_r == PWW_RUN) && $rose(cpu_rst_req) ##1 !cpu_rst_req;
    endproperty
    a_deep_wake: assert property (p_deep_wake)
        else $error("deep wakeup without a one-cycle cpu reset");

    property p_expire_sel;
        @(posedge clock) disable iff (!rst_n)
        expire |=> (sys_rst_req == !$past(rsel_r)) && fired_r
            && (count_r == '0);
    endproperty
    a_expire_sel: assert property (p_expire_sel)
        else $error("watchdog reset went to the wrong target");

    property p_clear_restart;
        @(posedge clock) disable iff (!rst_n)
        clear_hit |=> (count_r == '0) && !sys_rst_req && !$rose(fired_r);
    endproperty
    a_clear_restart: assert property (p_clear_restart)
        else $error("valid clear did not restart the count");

    property p_disabled_quiet;
        @(posedge clock) disable iff (!rst_n)
        !wd_en_r && !(wr_en && (addr == PWW_ADDR_CTRL)) |=> !sys_rst_req
            && (count_r == '0);
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("disabled watchdog acted");

    property p_period_default;
        @(posedge clock) disable iff (!rst_n)
        !$past(rst_n) |-> (psel_r == PWW_PSEL_DEFAULT)
            && (limit == (PWW_CNT_W'(WDOG_BASE) << PWW_PSEL_MAX));
    endproperty
    a_period_default: assert property (p_period_default)
        else $error("period after reset is not the longest");

    property p_bad_key;
        @(posedge clock) disable iff (!rst_n)
        wr_en && (addr == PWW_ADDR_CLEAR) && !clear_hit && wd_en_r && !wd_tick
            |=> (count_r == $past(count_r));
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("wrong key disturbed the count");

    property p_count_lowpower;
        @(posedge clock) disable iff (!rst_n)
        ((state_r == PWW_WAIT) || (state_r == PWW_HALT)) && wd_en_r && wd_tick
            && !clear_hit && !expire |=> (count_r == $past(count_r) + 1'b1);
    endproperty
    a_count_lowpower: assert property (p_count_lowpower)
        else $error("watchdog stalled in wait or halt");

    property p_stby_frozen;
        @(posedge clock) disable iff (!rst_n)
        (state_r == PWW_STBY) && wd_en_r && !clear_hit
            |=> (count_r == $past(count_r)) && !sys_rst_req;
    endproperty
    a_stby_frozen: assert property (p_stby_frozen)
        else $error("watchdog moved in standby");

endmodule : pww_core

// *** tb_top.sv ***
// Self-checking bench for the power-mode and watchdog block.
// Assumes the shortened divider and base period so that expiry takes a few cycles.
`timescale 1ns/1ps

module tb_top;
    import pww_pkg::*;

    // ==========================================================
    // Stimulus and observed signals
    logic                  clock = 1'b0;
    logic                  rst_n = 1'b0;
    logic [PWW_ADDR_W-1:0] addr = '0;
    logic [PWW_DATA_W-1:0] wr_data = '0;
    logic                  wr_en = 1'b0;
    logic                  rd_en = 1'b0;
    logic [PWW_DATA_W-1:0] rd_data;
    logic                  irq = 1'b0;
    logic                  cpu_clk_en;
    logic                  sys_clk_en;
    logic                  slow_clk_en;
    logic                  cpu_rst_req;
    logic                  sys_rst_req;
    int                    fail_count = 0;
    int                    tests_run = 0;
    int                    sys_n = 0;
    int                    cpu_n = 0;
    logic [15:0]           v;

    // Short counts keep one watchdog period at a handful of cycles
    pww_core #(.DIV_CYCLES(4), .WDOG_BASE(2)) dut_u (
        .clock       (clock),
        .rst_n       (rst_n),
        .addr        (addr),
        .wr_data     (wr_data),
        .wr_en       (wr_en),
        .rd_en       (rd_en),
        .rd_data     (rd_data),
        .irq         (irq),
        .cpu_clk_en  (cpu_clk_en),
        .sys_clk_en  (sys_clk_en),
        .slow_clk_en (slow_clk_en),
        .cpu_rst_req (cpu_rst_req),
        .sys_rst_req (sys_rst_req)
    );

    // 250 MHz clock
    always #2 clock = ~clock;

    // Reset pulse counters; sampled before the edge's own updates land
    always @(posedge clock) begin
        if (sys_rst_req === 1'b1) sys_n++;
        if (cpu_rst_req === 1'b1) cpu_n++;
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic bus_wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clock);
        wr_en   <= 1'b1;
        addr    <= a;
        wr_data <= d;
        @(posedge clock);
        wr_en   <= 1'b0;
    endtask : bus_wr

    // Read data stand only in the cycle after the read edge
    task automatic bus_rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clock);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask : bus_rd

    // Counts reset pulses over a fixed window starting at the last edge
    task automatic window(input int n);
        #1;
        sys_n = 0;
        cpu_n = 0;
        repeat (n) @(posedge clock);
        #1;
    endtask : window

    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    // ==========================================================
    // Register rows: write or read, index, data or expected read value
    typedef struct packed { logic wr; logic [2:0] a; logic [15:0] d; } pww_row_type;
    localparam pww_row_type ROWS [13] = '{
        '{1'b0, 3'h0, 16'h0015}, '{1'b0, 3'h1, 16'h0000}, '{1'b0, 3'h2, 16'h0000},
        '{1'b0, 3'h3, 16'h0000}, '{1'b1, 3'h0, 16'h0000}, '{1'b0, 3'h0, 16'h0000},
        '{1'b0, 3'h4, 16'h0000}, '{1'b1, 3'h0, 16'h001e}, '{1'b0, 3'h0, 16'h001e},
        '{1'b1, 3'h5, 16'hffff}, '{1'b0, 3'h5, 16'h0000}, '{1'b0, 3'h7, 16'h0000},
        '{1'b1, 3'h0, 16'h0000}};
    // Mode code and expected cpu, sys and slow enables
    localparam logic [4:0] MODES [3] = '{5'b01_011, 5'b10_001, 5'b11_000};

    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        // Reset values, read-back, unmapped and write-only places
        foreach (ROWS[i]) begin
            if (ROWS[i].wr) bus_wr(ROWS[i].a, ROWS[i].d);
            else begin
                bus_rd(ROWS[i].a, v);
                check("reg", v, ROWS[i].d);
            end
        end
        // Idle read port, then run ignores interrupts
        @(posedge clock);
        irq <= 1'b1;
        #1 check("rd_idle", rd_data, 16'h0000);
        window(3);
        check("run_irq", {sys_n[7:0], cpu_n[7:0]}, 16'h0000);
        check("run_cpu", {15'h0, cpu_clk_en}, 16'h0001);
        @(posedge clock);
        irq <= 1'b0;
        // Each low-power mode, a refused mode change, then wakeup
        foreach (MODES[i]) begin
            bus_wr(3'h1, {14'h0, MODES[i][4:3]});
            #1 check("en", {13'h0, cpu_clk_en, sys_clk_en, slow_clk_en}, MODES[i][2:0]);
            bus_wr(3'h1, 16'h0001);
            bus_rd(3'h1, v);
            check("mode", v, {14'h0, MODES[i][4:3]});
            window(4);
            check("asleep", {15'h0, cpu_clk_en}, 16'h0000);
            @(posedge clock);
            irq <= 1'b1;
            @(posedge clock);
            irq <= 1'b0;
            #1 check("wake", {15'h0, cpu_clk_en}, 16'h0001);
            check("wake_rst", {15'h0, cpu_rst_req}, {15'h0, i != 0});
            @(posedge clock);
            #1 check("wake_pulse", {15'h0, cpu_rst_req}, 16'h0000);
        end
        // Expiry with system reset, then with CPU reset
        bus_wr(3'h0, 16'h0001);
        window(10);
        check("exp_sys", {sys_n[7:0], cpu_n[7:0]}, 16'h0100);
        bus_wr(3'h0, 16'h0000);
        bus_rd(3'h3, v);
        check("stat_sys", v, 16'h0001);
        bus_wr(3'h3, 16'h0001);
        bus_wr(3'h0, 16'h0003);
        window(10);
        check("exp_cpu", {sys_n[7:0], cpu_n[7:0]}, 16'h0001);
        bus_wr(3'h0, 16'h0000);
        bus_rd(3'h3, v);
        check("stat_cpu", v, 16'h0003);
        // Keyed clears hold off expiry; wrong keys do not
        bus_wr(3'h0, 16'h0005);
        window(0);
        repeat (10) begin
            repeat (4) @(posedge clock);
            bus_wr(3'h2, 16'ha3c5);
        end
        check("cleared", {sys_n[7:0], cpu_n[7:0]}, 16'h0000);
        window(0);
        repeat (10) begin
            repeat (4) @(posedge clock);
            bus_wr(3'h2, 16'ha3c4);
            bus_wr(3'h2, 16'hb005);
        end
        check("bad_key", {15'h0, sys_n != 0}, 16'h0001);
        // Disabled watchdog never fires
        bus_wr(3'h0, 16'h0000);
        // An expiry on the disabling edge itself still pulses once; let it pass
        @(posedge clock);
        window(100);
        check("disabled", {sys_n[7:0], cpu_n[7:0]}, 16'h0000);
        // Still counting in halt; expiry returns to run
        bus_wr(3'h0, 16'h0001);
        bus_wr(3'h1, 16'h0002);
        window(8);
        check("halt_exp", {sys_n[7:0], cpu_n[7:0]}, 16'h0100);
        bus_rd(3'h1, v);
        check("halt_run", v, 16'h0000);
        bus_wr(3'h0, 16'h0000);
        // Frozen in standby
        bus_wr(3'h0, 16'h0001);
        bus_wr(3'h1, 16'h0003);
        window(60);
        check("stby", {sys_n[7:0], cpu_n[7:0]}, 16'h0000);
        bus_wr(3'h0, 16'h0000);
        irq <= 1'b1;
        @(posedge clock);
        @(posedge clock);
        irq <= 1'b0;
        #1 check("stby_wake", {15'h0, cpu_clk_en}, 16'h0001);
        // Reset in mid-run from halt: back to run with the longest period
        bus_wr(3'h1, 16'h0002);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        #1 check("rst_run", {15'h0, cpu_clk_en}, 16'h0001);
        bus_rd(3'h0, v);
        check("rst_ctrl", v, 16'h0015);
        bus_rd(3'h1, v);
        check("rst_mode", v, 16'h0000);
        conclude();
    end

    // Hang guard: counts as a mismatch and ends the run
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        conclude();
    end

endmodule : tb_top
